// *** hdl/lfm_fault_manager.sv ***
/*
 * led driver fault manager: undervoltage lockout, major fault off state, latching and
 * auto-recovery handling, gate drive pulse gating.
 * assumes comparator levels arrive asynchronously on pins; gate request and period strobe
 * come from logic on sys_clk_i.
 */
// Overview of operation
// - the undervoltage flag sets when the supply drops below turn-off and clears above turn-on, holding drive off.
// - any major fault puts the block into its off state.
// - in the off state no gate drive pulse is produced.
// - a latched fault keeps drive stopped until the supply falls below reset level, then operation resumes.
// - an auto-recovery fault blocks gate drive for a four second delay.
// - after the delay, operation restarts once the supply is above turn-on.
// - in the auto-recovery variant every major fault auto-recovers and nothing latches.
// - in the latching variant the pin over-temperature, programmable overvoltage, diode and winding shorts latch.
// - supply overvoltage always stops drive and auto-recovers in any variant.
// - a winding short is declared after four consecutive periods with current above the short limit.
`timescale 1ns/1ps
`include "lfm_regs.svh"

module lfm_fault_manager
    import lfm_pkg::*;
#(
    parameter bit LATCHING_VARIANT = 1'b0,
    parameter int unsigned RECOVERY_CYCLES = `LFM_RECOVERY_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic vcc_below_off_i,
    input wire logic vcc_above_on_i,
    input wire logic vcc_below_reset_i,
    input wire logic severe_otp_i,
    input wire logic vcc_ovp_i,
    input wire logic programmable_overvoltage_fault_i,
    input wire logic diode_short_fault_i,
    input wire logic die_overtemp_fault_i,
    input wire logic cs_over_short_limit_i,
    input wire logic switch_period_end_i,
    input wire logic drive_request_i,
    output logic gate_drive_pulse_o,
    output logic supply_undervoltage_flag_o,
    output logic off_state_o,
    output logic latched_off_o,
    output logic recovery_delay_o,
    output logic winding_short_fault_o
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    // comparator outputs are asynchronous; two stages keep metastability out of the logic
    logic [`LFM_PIN_W-1:0] pin_meta_q;
    logic [`LFM_PIN_W-1:0] pin_q;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pin_meta_q <= '0;
            pin_q <= '0;
        end else begin
            pin_meta_q <= {cs_over_short_limit_i, die_overtemp_fault_i, diode_short_fault_i,
                           programmable_overvoltage_fault_i, vcc_ovp_i, severe_otp_i,
                           vcc_below_reset_i, vcc_above_on_i, vcc_below_off_i};
            pin_q <= pin_meta_q;
        end
    end

    // ****************************************
    // winding short detector
    // ****************************************
    lfm_scp_if scp (
        .clk(sys_clk_i),
        .rst(rst_i)
    );

    assign scp.period_end = switch_period_end_i;
    assign scp.over_limit = pin_q[`LFM_PIN_CS_OVER_LIMIT];

    lfm_winding_short_det u_scp (
        .scp(scp)
    );

    // ****************************************
    // fault classification
    // ****************************************
    // variant-dependent faults; supply overvoltage and die temperature never latch
    function automatic logic latch_class(input logic [`LFM_PIN_W-1:0] p, input logic wshort, input bit variant);
        logic hit;
        hit = p[`LFM_PIN_SEVERE_OTP] | p[`LFM_PIN_PROG_OVP] | p[`LFM_PIN_DIODE_SHORT] | wshort;
        return variant & hit;
    endfunction

    logic any_fault;
    logic latch_fault;
    logic auto_fault;

    assign any_fault = pin_q[`LFM_PIN_SEVERE_OTP] | pin_q[`LFM_PIN_VCC_OVP] | pin_q[`LFM_PIN_PROG_OVP]
                     | pin_q[`LFM_PIN_DIODE_SHORT] | pin_q[`LFM_PIN_DIE_OVERTEMP] | scp.fault;
    assign latch_fault = latch_class(pin_q, scp.fault, LATCHING_VARIANT);
    assign auto_fault = any_fault & ~latch_fault;

    // ****************************************
    // undervoltage flag
    // ****************************************
    logic supply_undervoltage_flag_q;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            supply_undervoltage_flag_q <= 1'b1;
        // below-off wins when both comparators read high
        end else if (pin_q[`LFM_PIN_VCC_BELOW_OFF]) begin
            supply_undervoltage_flag_q <= 1'b1;
        end else if (pin_q[`LFM_PIN_VCC_ABOVE_ON]) begin
            supply_undervoltage_flag_q <= 1'b0;
        end
    end

    // ****************************************
    // off state sequencing
    // ****************************************
    lfm_state_e state_q;
    logic [`LFM_RECOVERY_CNT_W-1:0] delay_cnt_q;
    logic delay_done;

    // counter width covers the full four second count at the nominal clock
    assign delay_done = (delay_cnt_q == `LFM_RECOVERY_CNT_W'(RECOVERY_CYCLES - 1));

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_q <= LFM_ST_UNDERVOLT;
        end else begin
            // a latch-class fault wins over an auto-recovery one in every state
            unique case (state_q)
                LFM_ST_UNDERVOLT: begin
                    if (latch_fault) begin
                        state_q <= LFM_ST_LATCHED;
                    end else if (auto_fault) begin
                        state_q <= LFM_ST_RECOVER_WAIT;
                    end else if (!supply_undervoltage_flag_q) begin
                        state_q <= LFM_ST_RUN;
                    end
                end
                LFM_ST_RUN: begin
                    if (latch_fault) begin
                        state_q <= LFM_ST_LATCHED;
                    end else if (auto_fault) begin
                        state_q <= LFM_ST_RECOVER_WAIT;
                    end else if (supply_undervoltage_flag_q) begin
                        state_q <= LFM_ST_UNDERVOLT;
                    end
                end
                LFM_ST_LATCHED: begin
                    // only a supply drop to reset level releases the latch
                    if (pin_q[`LFM_PIN_VCC_BELOW_RESET]) begin
                        state_q <= LFM_ST_UNDERVOLT;
                    end
                end
                LFM_ST_RECOVER_WAIT: begin
                    if (latch_fault) begin
                        state_q <= LFM_ST_LATCHED;
                    end else if (delay_done) begin
                        state_q <= LFM_ST_RECOVER_ARM;
                    end
                end
                LFM_ST_RECOVER_ARM: begin
                    // a fault still present sends it back to the recovery delay, or to the latch
                    if (latch_fault) begin
                        state_q <= LFM_ST_LATCHED;
                    end else if (auto_fault) begin
                        state_q <= LFM_ST_RECOVER_WAIT;
                    end else if (!supply_undervoltage_flag_q && pin_q[`LFM_PIN_VCC_ABOVE_ON]) begin
                        state_q <= LFM_ST_RUN;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // recovery delay counter
    // ****************************************
    // long count kept as a parameter so a bench can shorten it
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            delay_cnt_q <= '0;
        end else if (state_q == LFM_ST_RECOVER_WAIT && !delay_done) begin
            delay_cnt_q <= delay_cnt_q + `LFM_RECOVERY_CNT_W'(1);
        end else begin
            delay_cnt_q <= '0;
        end
    end

    // ****************************************
    // gate drive and status outputs
    // ****************************************
    // fault terms gate the pulse in the same cycle, before the state catches up
    // request honoured only in run with the supply good
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            gate_drive_pulse_o <= 1'b0;
        end else begin
            gate_drive_pulse_o <= drive_request_i && state_q == LFM_ST_RUN && !any_fault && !supply_undervoltage_flag_q;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            supply_undervoltage_flag_o <= 1'b1;
            off_state_o <= 1'b1;
            latched_off_o <= 1'b0;
            recovery_delay_o <= 1'b0;
            winding_short_fault_o <= 1'b0;
        end else begin
            supply_undervoltage_flag_o <= supply_undervoltage_flag_q;
            off_state_o <= state_q != LFM_ST_RUN;
            latched_off_o <= state_q == LFM_ST_LATCHED;
            recovery_delay_o <= state_q == LFM_ST_RECOVER_WAIT;
            winding_short_fault_o <= scp.fault;
        end
    end

endmodule

// *** hdl/lfm_regs.svh ***
/*
 * constants of the led driver fault manager: pin vector positions, counts, timing.
 * assumes inclusion by bare name from design files only.
 */
`ifndef LFM_REGS_SVH
`define LFM_REGS_SVH

// ****************************************
// synchronised pin vector positions
// ****************************************
`define LFM_PIN_W 9
`define LFM_PIN_VCC_BELOW_OFF 0
`define LFM_PIN_VCC_ABOVE_ON 1
`define LFM_PIN_VCC_BELOW_RESET 2
`define LFM_PIN_SEVERE_OTP 3
`define LFM_PIN_VCC_OVP 4
`define LFM_PIN_PROG_OVP 5
`define LFM_PIN_DIODE_SHORT 6
`define LFM_PIN_DIE_OVERTEMP 7
`define LFM_PIN_CS_OVER_LIMIT 8

// ****************************************
// timing
// ****************************************
`define LFM_CLK_KHZ 25000
`define LFM_RECOVERY_DELAY_MS 4000
`define LFM_RECOVERY_CYCLES (`LFM_RECOVERY_DELAY_MS * `LFM_CLK_KHZ)
`define LFM_RECOVERY_CNT_W 27

// ****************************************
// winding short detection
// ****************************************
`define LFM_SCP_PERIODS 4
`define LFM_SCP_CNT_W 3

`endif

// *** hdl/lfm_pkg.sv ***
/*
 * types of the led driver fault manager.
 * assumes nothing beyond a systemverilog compiler.
 */
package lfm_pkg;

    typedef enum logic [2:0] {
        LFM_ST_UNDERVOLT,
        LFM_ST_RUN,
        LFM_ST_LATCHED,
        LFM_ST_RECOVER_WAIT,
        LFM_ST_RECOVER_ARM
    } lfm_state_e;

endpackage

// *** hdl/lfm_scp_if.sv ***
/*
 * carrier between the fault manager and its winding short detector.
 * assumes inputs already synchronised to clk.
 */
`timescale 1ns/1ps

interface lfm_scp_if (
    input wire logic clk,
    input wire logic rst
);
    logic period_end;
    logic over_limit;
    logic fault;

    modport det (
        input clk,
        input rst,
        input period_end,
        input over_limit,
        output fault
    );

    modport mgr (
        output period_end,
        output over_limit,
        input fault
    );
endinterface

// *** hdl/lfm_winding_short_det.sv ***
/*
 * winding short detector: counts consecutive switching periods with current over the short limit.
 * assumes one-cycle period_end strobe and synchronised over_limit level.
 */
`timescale 1ns/1ps
`include "lfm_regs.svh"

module lfm_winding_short_det
    import lfm_pkg::*;
(
    lfm_scp_if.det scp
);

    logic [`LFM_SCP_CNT_W-1:0] cnt_q;
    logic seen_q;
    logic fault_q;

    // ****************************************
    // per-period overshoot memory
    // ****************************************
    always_ff @(posedge scp.clk) begin
        if (scp.rst) begin
            seen_q <= 1'b0;
        end else if (scp.period_end) begin
            seen_q <= 1'b0;
        end else if (scp.over_limit) begin
            seen_q <= 1'b1;
        end
    end

    // ****************************************
    // consecutive period count
    // ****************************************
    always_ff @(posedge scp.clk) begin
        if (scp.rst) begin
            cnt_q <= '0;
            fault_q <= 1'b0;
        end else begin
            fault_q <= 1'b0;
            if (scp.period_end) begin
                if (seen_q || scp.over_limit) begin
                    if (cnt_q == `LFM_SCP_CNT_W'(`LFM_SCP_PERIODS - 1)) begin
                        cnt_q <= '0;
                        fault_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + `LFM_SCP_CNT_W'(1);
                    end
                end else begin
                    // a clean period breaks the run
                    cnt_q <= '0;
                end
            end
        end
    end

    assign scp.fault = fault_q;

endmodule

// *** test/lfm_fault_manager_sva.sv ***
/*
 * port assertions of the fault manager: gating, latching, recovery, winding short.
 * assumes binding to lfm_fault_manager with its parameters handed on.
 */
`timescale 1ns/1ps
// ****
// checker
// ****
module lfm_fault_manager_sva #(
    parameter bit LATCHING_VARIANT = 1'b0,
    parameter int unsigned RECOVERY_CYCLES = 20
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic vcc_below_reset_i,
    input wire logic severe_otp_i,
    input wire logic vcc_ovp_i,
    input wire logic programmable_overvoltage_fault_i,
    input wire logic diode_short_fault_i,
    input wire logic die_overtemp_fault_i,
    input wire logic switch_period_end_i,
    input wire logic gate_drive_pulse_o,
    input wire logic supply_undervoltage_flag_o,
    input wire logic off_state_o,
    input wire logic latched_off_o,
    input wire logic recovery_delay_o,
    input wire logic winding_short_fault_o
);
    logic [31:0] high_q;
    logic any_fault;
    assign any_fault = severe_otp_i | vcc_ovp_i | programmable_overvoltage_fault_i | diode_short_fault_i |
        die_overtemp_fault_i;
    // length of the recovery flag, so a short delay is caught
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !recovery_delay_o) begin
            high_q <= '0;
        end else begin
            high_q <= high_q + 32'h1;
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_off_no_gate: assert property (off_state_o |-> !gate_drive_pulse_o)
        else $error("gate pulse while off");
    a_supply_undervoltage_flag_no_gate: assert property (supply_undervoltage_flag_o |-> !gate_drive_pulse_o)
        else $error("gate pulse under undervoltage");
    a_fault_stops_gate: assert property (any_fault [*5] |-> !gate_drive_pulse_o)
        else $error("gate pulse during fault");
    a_latch_holds: assert property ((latched_off_o && !vcc_below_reset_i) [*4] |=> latched_off_o)
        else $error("latch left without reset level");
    a_auto_never_latch: assert property (!LATCHING_VARIANT |-> !latched_off_o)
        else $error("latch in auto variant");
    a_recovery_is_off: assert property (recovery_delay_o |-> off_state_o && !latched_off_o)
        else $error("recovery flag outside off state");
    a_recovery_length: assert property ($fell(recovery_delay_o) && !latched_off_o |-> high_q >= RECOVERY_CYCLES)
        else $error("recovery delay too short");
    a_short_at_period: assert property (winding_short_fault_o |-> $past(switch_period_end_i, 2))
        else $error("winding short not after period end");
    a_short_spacing: assert property (winding_short_fault_o |=> !winding_short_fault_o [*3])
        else $error("winding short pulses too close");
endmodule

bind lfm_fault_manager lfm_fault_manager_sva #(.LATCHING_VARIANT(LATCHING_VARIANT),
    .RECOVERY_CYCLES(RECOVERY_CYCLES)) u_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .vcc_below_reset_i(vcc_below_reset_i), .severe_otp_i(severe_otp_i), .vcc_ovp_i(vcc_ovp_i),
    .programmable_overvoltage_fault_i(programmable_overvoltage_fault_i), .diode_short_fault_i(diode_short_fault_i),
    .die_overtemp_fault_i(die_overtemp_fault_i), .switch_period_end_i(switch_period_end_i),
    .gate_drive_pulse_o(gate_drive_pulse_o), .supply_undervoltage_flag_o(supply_undervoltage_flag_o),
    .off_state_o(off_state_o), .latched_off_o(latched_off_o), .recovery_delay_o(recovery_delay_o),
    .winding_short_fault_o(winding_short_fault_o));

// *** test/tb_top.sv ***
/*
 * bench of the fault manager: random gate requests, each major fault, latch and recovery exits.
 * assumes the design and checker compiled first; one 25 MHz clock.
 */
`timescale 1ns/1ps
// ****
// bench
// ****
module tb_top;
    localparam bit LV = 1'b1;
    localparam int RC = 20;
    logic sys_clk_i, rst_i, boff, aon, brst, cs, pend, req, req_s, seen, gchk;
    logic gate, supply_undervoltage_flag, off, lat, rec, wsf;
    logic gate2, off2, lat2, rec2;
    logic [4:0] flt;
    int n_errors, total_checks, cyc;
    integer seed;

    lfm_fault_manager #(.LATCHING_VARIANT(LV), .RECOVERY_CYCLES(RC)) DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .vcc_below_off_i(boff), .vcc_above_on_i(aon), .vcc_below_reset_i(brst), .severe_otp_i(flt[0]),
        .vcc_ovp_i(flt[1]), .programmable_overvoltage_fault_i(flt[2]), .diode_short_fault_i(flt[3]),
        .die_overtemp_fault_i(flt[4]), .cs_over_short_limit_i(cs), .switch_period_end_i(pend),
        .drive_request_i(req), .gate_drive_pulse_o(gate), .supply_undervoltage_flag_o(supply_undervoltage_flag),
        .off_state_o(off), .latched_off_o(lat), .recovery_delay_o(rec), .winding_short_fault_o(wsf));

    // auto-recovery build on the same pins, so the never-latch behaviour is exercised
    lfm_fault_manager #(.LATCHING_VARIANT(1'b0), .RECOVERY_CYCLES(RC)) DUT_AUTO (.sys_clk_i(sys_clk_i),
        .rst_i(rst_i), .vcc_below_off_i(boff), .vcc_above_on_i(aon), .vcc_below_reset_i(brst),
        .severe_otp_i(flt[0]), .vcc_ovp_i(flt[1]), .programmable_overvoltage_fault_i(flt[2]),
        .diode_short_fault_i(flt[3]), .die_overtemp_fault_i(flt[4]), .cs_over_short_limit_i(cs),
        .switch_period_end_i(pend), .drive_request_i(req), .gate_drive_pulse_o(gate2),
        .supply_undervoltage_flag_o(), .off_state_o(off2), .latched_off_o(lat2), .recovery_delay_o(rec2),
        .winding_short_fault_o());

    // index 5 is the winding short
    function automatic logic exp_latch(input int i);
        return LV && (i == 0 || i == 2 || i == 3 || i == 5);
    endfunction

    task chk(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t: got %b expected %b", $time, got, exp);
        end
    endtask

    task wait_n(input int n);
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask

    // over-limit held three cycles so the two-stage sync sees it before the period ends
    task period(input logic over);
        @(posedge sys_clk_i);
        cs <= over;
        repeat (3) @(posedge sys_clk_i);
        cs <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        pend <= 1'b1;
        @(posedge sys_clk_i);
        pend <= 1'b0;
    endtask

    task final_report;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        req <= 1'($random(seed));
        req_s <= req;
        if (wsf === 1'b1) seen <= 1'b1;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            final_report();
        end
    end

    always @(negedge sys_clk_i) begin
        if (gchk) chk(gate, req_s);
        if (gchk) chk(gate2, req_s);
    end

    initial begin
        seed = 32'hc803ab17;
        {rst_i, boff, aon, brst, cs, pend, req, seen, gchk, flt} = {1'b1, 13'h0};
        n_errors = 0;
        total_checks = 0;
        cyc = 0;
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        wait_n(6);
        chk(supply_undervoltage_flag, 1'b1);
        @(posedge sys_clk_i);
        aon <= 1'b1;
        wait_n(8);
        chk(off, 1'b0);
        gchk = 1'b1;
        wait_n(30);
        gchk = 1'b0;
        @(posedge sys_clk_i);
        {boff, aon} <= 2'b10;
        wait_n(8);
        chk(supply_undervoltage_flag, 1'b1);
        @(posedge sys_clk_i);
        boff <= 1'b0;
        wait_n(8);
        chk(supply_undervoltage_flag, 1'b1);
        @(posedge sys_clk_i);
        aon <= 1'b1;
        wait_n(8);
        chk(supply_undervoltage_flag, 1'b0);
        for (int i = 0; i < 6; i++) begin
            gchk = 1'b0;
            @(posedge sys_clk_i);
            if (i == 5) begin
                repeat (3) period(1'b1);
                period(1'b0);
                repeat (3) period(1'b1);
                wait_n(3);
                chk(seen, 1'b0);
                chk(off, 1'b0);
                period(1'b1);
                wait_n(3);
                chk(seen, 1'b1);
            end else begin
                flt[i] <= 1'b1;
                wait_n(8);
            end
            chk(off, 1'b1);
            chk(gate, 1'b0);
            chk(lat, exp_latch(i));
            chk(rec, !exp_latch(i));
            chk(lat2, 1'b0);
            chk(rec2, 1'b1);
            @(posedge sys_clk_i);
            flt <= '0;
            aon <= (i != 1);
            wait_n(5);
            chk(off, 1'b1);
            @(posedge sys_clk_i);
            brst <= exp_latch(i);
            wait_n(exp_latch(i) ? 6 : RC + 10);
            chk(lat, 1'b0);
            chk(off, i == 1);
            chk(off2, i != 4);
            @(posedge sys_clk_i);
            {brst, aon} <= 2'b01;
            wait_n(10);
            chk(off, 1'b0);
            chk(off2, 1'b0);
            gchk = 1'b1;
            wait_n(10);
        end
        final_report();
    end
endmodule
